// file: bench/dma_controller_chk.sv
// port-level assertions for the dma controller
// assumes one clock, pclk, and async active-low presetn
`timescale 1ns/1ps
`default_nettype none
module dma_controller_chk (
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pready,
  input wire logic [dma_pkg::NCH-1:0] periph_ack,
  input wire dma_pkg::bus_req_s       mem_bus,
  input wire logic                    bus_ready,
  input wire logic                    bus_err
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // clean write beat, two cycles before any ack
  logic wr_ok;
  assign wr_ok = mem_bus.req && mem_bus.write && bus_ready && !bus_err;
  // byte read done, then the write carrying it
  sequence rd8_done;
    mem_bus.req && !mem_bus.write && mem_bus.size == dma_pkg::SZ_8 && bus_ready && !bus_err;
  endsequence
  sequence wr_beat;
    mem_bus.req && mem_bus.write;
  endsequence
  a_ready_follows: assert property (psel && !penable |=> pready)
    else $error("no pready after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ack_pulse: assert property (|periph_ack |=> periph_ack == '0)
    else $error("ack longer than one cycle");
  a_ack_onehot: assert property ($onehot0(periph_ack))
    else $error("two channels acked at once");
  a_bus_hold: assert property (mem_bus.req && !bus_ready |=> mem_bus.req && $stable(mem_bus))
    else $error("bus request changed before ready");
  a_read_write: assert property (mem_bus.req && !mem_bus.write && bus_ready && !bus_err |=> wr_beat)
    else $error("read not followed by write");
  a_ack_after_wr: assert property (|periph_ack |-> $past(wr_ok, 2))
    else $error("ack without completed write");
  a_fault_no_ack: assert property (mem_bus.req && bus_ready && bus_err |=> (periph_ack == '0) [*4])
    else $error("ack after failed access");
  a_zero_ext: assert property (rd8_done ##1 wr_beat |-> mem_bus.wdata[31:8] == '0)
    else $error("byte data not zero extended");
  a_size_legal: assert property (mem_bus.req |-> mem_bus.size != 2'h3)
    else $error("reserved width code on bus");
endmodule
bind dma_controller dma_controller_chk dma_controller_chk_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready), .periph_ack(periph_ack), .mem_bus(mem_bus),
  .bus_ready(bus_ready), .bus_err(bus_err));
`default_nettype wire

// file: bench/dma_mem_model.sv
// system bus memory: flash/sram reads, ram writes, optional stalls
// assumes the master holds its request until ready
`timescale 1ns/1ps
`default_nettype none
module dma_mem_model (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire dma_pkg::bus_req_s bus,
  input wire logic              slow,
  input wire logic              fault,
  output logic                  ready,
  output logic [31:0]           rdata,
  output logic                  err,
  output logic [31:0]           raddr,
  output logic [31:0]           waddr,
  output logic [31:0]           wdata,
  output logic [15:0]           wcount
);
  logic        tick; // stall phase, every other cycle when slow
  logic [31:0] last; // last data handed back
  assign ready = bus.req && (!slow || tick);
  // data made from address; inverse of last word when idle
  assign rdata = ready ? {~bus.addr[15:0], bus.addr[15:0]} : ~last;
  assign err = ready && fault;
  // record the latest read address and write beat
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick <= 1'b0;
      last <= '0;
      raddr <= '0;
      waddr <= '0;
      wdata <= '0;
      wcount <= '0;
    end else begin
      tick <= ~tick;
      if (ready && !bus.write) begin
        last <= rdata;
        raddr <= bus.addr;
      end
      if (ready && bus.write) begin
        waddr <= bus.addr;
        wdata <= bus.wdata;
        wcount <= wcount + 16'h1;
      end
    end
  end
endmodule
`default_nettype wire

// file: bench/tb_five_channel_dma_controller.sv
// self-checking bench for the five-channel dma controller
// assumes the memory model on the system bus, pclk at 100 mhz
`timescale 1ns/1ps
`default_nettype none
module tb_five_channel_dma_controller;
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [7:0]        paddr = '0;
  logic [31:0]       pwdata = '0;
  logic [79:0]       periph_req = '0;
  logic              slow = 1'b0;
  logic              fault = 1'b0;
  logic [31:0]       prdata, bus_rdata, raddr, waddr, wdata, rd;
  logic              pready, pslverr, bus_ready, bus_err, err;
  logic [4:0]        periph_ack, irq;
  logic [15:0]       wcount;
  dma_pkg::bus_req_s mem_bus;
  int                err_count = 0;
  int                compares = 0;
  int                cyc = 0;
  always #5 pclk = ~pclk;
  dma_controller dma_controller_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .periph_req(periph_req),
    .system_remap_config(5'h0), .periph_ack(periph_ack), .mem_bus(mem_bus),
    .bus_ready(bus_ready), .bus_rdata(bus_rdata), .bus_err(bus_err), .irq(irq));
  dma_mem_model dma_mem_model_i (.pclk(pclk), .presetn(presetn), .bus(mem_bus),
    .slow(slow), .fault(fault), .ready(bus_ready), .rdata(bus_rdata), .err(bus_err),
    .raddr(raddr), .waddr(waddr), .wdata(wdata), .wcount(wcount));
  // hang guard, far above the run's length
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      give_verdict();
    end
  end
  function automatic logic [7:0] ra(input int c, input logic [4:0] r);
    return dma_pkg::OFS_CH_BASE + 8'(c) * dma_pkg::OFS_CH_STRIDE + 8'(r);
  endfunction
  // one apb transfer; held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic t_regs();
    rdc(dma_pkg::OFS_STATUS, 32'h0);
    apb(1'b1, ra(4, dma_pkg::REG_COUNT), 32'h0000_ffff);
    rdc(ra(4, dma_pkg::REG_COUNT), 32'h0000_ffff);
    apb(1'b1, ra(4, dma_pkg::REG_CFG), 32'h0000_0001);
    apb(1'b1, ra(4, dma_pkg::REG_COUNT), 32'h0000_0005);
    rdc(ra(4, dma_pkg::REG_COUNT), 32'h0000_ffff);
    apb(1'b1, ra(4, dma_pkg::REG_CFG), 32'h0);
    apb(1'b1, 8'hc0, 32'h1);
    chk({31'h0, err}, 32'h1);
    $display("regs done");
  endtask
  // fixed byte source into rising word addresses, slow bus
  task automatic t_m2m();
    slow <= 1'b1;
    apb(1'b1, ra(0, dma_pkg::REG_PADDR), 32'h0000_01a4);
    apb(1'b1, ra(0, dma_pkg::REG_MADDR), 32'h0000_2000);
    apb(1'b1, ra(0, dma_pkg::REG_COUNT), 32'h0000_0002);
    apb(1'b1, ra(0, dma_pkg::REG_CFG), 32'h0000_4881);
    while (wcount < 16'h2) @(posedge pclk);
    chk(raddr, 32'h0000_01a4);
    chk(waddr, 32'h0000_2004);
    chk(wdata, 32'h0000_00a4);
    rdc(dma_pkg::OFS_STATUS, 32'h0000_0007);
    rdc(ra(0, dma_pkg::REG_COUNT), 32'h0);
    apb(1'b1, dma_pkg::OFS_CLEAR, 32'h0000_0001);
    rdc(dma_pkg::OFS_STATUS, 32'h0);
    apb(1'b1, ra(0, dma_pkg::REG_CFG), 32'h0);
    slow <= 1'b0;
    $display("m2m done");
  endtask
  // one word from line 0, the only line enabled
  task automatic run_one(input int c, input logic [1:0] p);
    apb(1'b1, ra(c, dma_pkg::REG_COUNT), 32'h1);
    apb(1'b1, ra(c, dma_pkg::REG_CFG), 32'h0a01 | (32'(p) << 12));
  endtask
  // waits for an ack, drops that request at its edge
  task automatic take_ack(input int c);
    do @(posedge pclk); while (periph_ack === 5'h0);
    chk({27'h0, periph_ack}, 32'h1 << c);
    periph_req[c * 16] <= 1'b0;
  endtask
  // b must be served before a
  task automatic t_pair(input int a, input int b, input logic [1:0] pa, input logic [1:0] pb);
    run_one(a, pa);
    run_one(b, pb);
    periph_req[a * 16] <= 1'b1;
    periph_req[b * 16] <= 1'b1;
    take_ack(b);
    take_ack(a);
    rdc(dma_pkg::OFS_STATUS, (32'h7 << 4 * a) | (32'h7 << 4 * b));
    apb(1'b1, dma_pkg::OFS_CLEAR, 32'h000f_ffff);
    $display("pair done");
  endtask
  task automatic t_fault();
    fault <= 1'b1;
    apb(1'b1, ra(0, dma_pkg::REG_COUNT), 32'h1);
    apb(1'b1, ra(0, dma_pkg::REG_CFG), 32'h0000_4889);
    while (irq[0] !== 1'b1) @(posedge pclk);
    fault <= 1'b0;
    rdc(dma_pkg::OFS_STATUS, 32'h0000_0009);
    rdc(ra(0, dma_pkg::REG_CFG), 32'h0000_4888);
    apb(1'b1, dma_pkg::OFS_CLEAR, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    chk({27'h0, irq}, 32'h0);
    apb(1'b1, dma_pkg::OFS_FORCE, 32'h0000_0020);
    rdc(dma_pkg::OFS_STATUS, 32'h0000_0030);
    apb(1'b1, dma_pkg::OFS_CLEAR, 32'h0000_0010);
    rdc(dma_pkg::OFS_STATUS, 32'h0);
    $display("fault done");
  endtask
  task automatic give_verdict();
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_m2m();
    t_pair(1, 2, 2'h1, 2'h3);
    t_pair(4, 3, 2'h2, 2'h2);
    t_fault();
    give_verdict();
  end
endmodule
`default_nettype wire

// file: hdl/dma_controller.sv
// five-channel dma controller: apb register slave, request routing,
// arbitration and a read-then-write system bus master.
// assumes peripherals and bus run on pclk; no synchronisers needed.
`timescale 1ns/1ps
`default_nettype none

// Operation
// (R1) five channels, one active request each
// (R2) peripheral-memory both ways, memory-memory
// (R3) per-channel item count up to 65535
// (R4) peripheral waits for acknowledge per item
// (R5) three flags per channel, irq, software trigger
// (R6) software enables one source per channel
// (R7) small variant: remap bit picks channel line
// (R8) large variant: 4-bit source selector per channel
// (R9) periph and memory widths 8/16/32 independently
// (R10) narrow source zero-extends, wide source truncates
// (R11) each address fixed or incrementing
// (R12) increment equals side width in bytes
// (R13) stop at zero; count written only disabled
// (R14) circular reloads count and both addresses
// (R15) circular runs until circular_en cleared
// (R16) highest software priority wins first
// (R17) priority code 00 low to 11 highest
// (R18) equal priority: lower channel number wins
// (R19) memory reads flash/sram, writes ram
// (R20) memory-to-memory runs without any request
// (R21) direction 0 periph-to-mem, 1 mem-to-periph
// (R22) width code 00/01/10, 11 reserved
// (R23) half at count/2, done at zero, fault
// (R24) flags cleared by writing one to clear
module dma_controller #(
  parameter bit LARGE_VARIANT = 1'b1             // 1: selector, 0: remap
) (
  input  wire logic                             pclk,
  input  wire logic                             presetn,
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [7:0]                       paddr,
  input  wire logic [31:0]                      pwdata,
  output logic [31:0]                           prdata,
  output logic                                  pready,
  output logic                                  pslverr,
  input  wire logic [dma_pkg::NCH*dma_pkg::NSRC-1:0] periph_req,
  input  wire logic [dma_pkg::NCH-1:0]          system_remap_config,
  output logic [dma_pkg::NCH-1:0]               periph_ack,
  output dma_pkg::bus_req_s                     mem_bus,
  input  wire logic                             bus_ready,
  input  wire logic [31:0]                      bus_rdata,
  input  wire logic                             bus_err,
  output logic [dma_pkg::NCH-1:0]               irq
);
  // whole module state
  typedef struct packed {
    dma_pkg::dma_st_e                  fsm;
    logic [2:0]                        cur;      // channel being served
    logic [31:0]                       data;     // item in flight
    dma_pkg::bus_req_s                 bus;
    logic [dma_pkg::NCH-1:0]           ack;
    logic [dma_pkg::NCH-1:0]           irq;
    logic [31:0]                       prdata;
    logic                              pready;
    logic                              pslverr;
    dma_pkg::chan_s [dma_pkg::NCH-1:0] ch;
  } state_s;

  state_s                   st;                  // registered state
  state_s                   next_st;             // next state
  logic [dma_pkg::NCH-1:0]  want;                // channels ready to move
  logic [2*dma_pkg::NCH-1:0] prio_vec;           // sw_priority per channel
  logic                     grant_any;           // some channel wants
  logic [2:0]               grant_idx;           // winning channel

  // byte mask of a width code; source data is cut to it
  function automatic logic [31:0] width_mask(input logic [1:0] sz);
    unique case (sz)
      dma_pkg::SZ_8:  width_mask = 32'h0000_00ff;
      dma_pkg::SZ_16: width_mask = 32'h0000_ffff;
      default:        width_mask = 32'hffff_ffff;
    endcase
  endfunction

  // address step of a width code: 1, 2 or 4 bytes
  function automatic logic [31:0] width_step(input logic [1:0] sz);
    unique case (sz)
      dma_pkg::SZ_8:  width_step = 32'h0000_0001;
      dma_pkg::SZ_16: width_step = 32'h0000_0002;
      default:        width_step = 32'h0000_0004;
    endcase
  endfunction

  // request routing and per-channel readiness
  always_comb begin
    logic [3:0] code;
    logic       line;
    code = 4'h0;
    line = 1'b0;
    want = '0;
    prio_vec = '0;
    for (int c = 0; c < dma_pkg::NCH; c++) begin
      // small part: line 0 default, line 1 the remapped source
      code = LARGE_VARIANT ? st.ch[c].sel                       // (R8)
                           : {3'b000, system_remap_config[c]};  // (R7)
      // one line per channel is served; software keeps others off
      line = periph_req[c*dma_pkg::NSRC + int'(code)];          // (R1) (R6)
      want[c] = st.ch[c].cfg[dma_pkg::B_ON]
              && (st.ch[c].count != 16'h0000)                   // (R13)
              && (st.ch[c].cfg[dma_pkg::B_M2M] || line);        // (R20) (R4)
      prio_vec[2*c +: 2] = st.ch[c].cfg[dma_pkg::B_PRIO +: 2];  // (R17)
    end
  end

  // single-pass priority pick, lowest channel on a tie
  dma_arbiter #(
    .N  (dma_pkg::NCH),
    .IW (3)
  ) u_arbiter (
    .want (want),
    .prio (prio_vec),
    .any  (grant_any),
    .pick (grant_idx)
  );

  // register access, flags and the transfer engine
  always_comb begin
    logic [7:0]     rel;
    logic [2:0]     chi;
    logic [4:0]     rof;
    logic           in_ch;
    logic           hit;
    logic           wr;
    logic           dir;
    logic [1:0]     src_sz;
    logic [1:0]     dst_sz;
    dma_pkg::chan_s k;
    next_st = st;
    rel     = paddr - dma_pkg::OFS_CH_BASE;
    chi     = 3'(rel / dma_pkg::OFS_CH_STRIDE);
    rof     = 5'(rel % dma_pkg::OFS_CH_STRIDE);
    in_ch   = (paddr >= dma_pkg::OFS_CH_BASE) && (paddr < dma_pkg::OFS_CH_END)
            && (rof <= dma_pkg::REG_MADDR) && (paddr[1:0] == 2'b00);
    hit     = in_ch || (paddr == dma_pkg::OFS_STATUS)
            || (paddr == dma_pkg::OFS_CLEAR) || (paddr == dma_pkg::OFS_SELECT)
            || (paddr == dma_pkg::OFS_FORCE);
    wr      = psel && penable && pwrite && st.pready;
    dir     = 1'b0;
    src_sz  = 2'b00;
    dst_sz  = 2'b00;
    k       = st.ch[st.cur];
    next_st.ack     = '0;
    next_st.pready  = 1'b0;
    next_st.pslverr = 1'b0;

    // setup phase: answer prepared so access takes one cycle
    if (psel && !penable) begin
      next_st.pready  = 1'b1;
      next_st.pslverr = !hit;
      next_st.prdata  = 32'h0000_0000;
      if (!pwrite) begin
        if (paddr == dma_pkg::OFS_STATUS) begin
          for (int c = 0; c < dma_pkg::NCH; c++) begin
            next_st.prdata[4*c + dma_pkg::F_DONE] = st.ch[c].all_done_flag;
            next_st.prdata[4*c + dma_pkg::F_HALF] = st.ch[c].half_done_flag;
            next_st.prdata[4*c + dma_pkg::F_FLT]  = st.ch[c].transfer_fault_flag;
            next_st.prdata[4*c + dma_pkg::F_ANY]  = st.ch[c].all_done_flag
              || st.ch[c].half_done_flag || st.ch[c].transfer_fault_flag;
          end
        end else if (paddr == dma_pkg::OFS_SELECT) begin
          for (int c = 0; c < dma_pkg::NCH; c++) begin
            next_st.prdata[4*c +: 4] = st.ch[c].sel;
          end
        end else if (in_ch) begin
          unique case (rof)
            dma_pkg::REG_CFG:   next_st.prdata = 32'(st.ch[chi].cfg);
            dma_pkg::REG_COUNT: next_st.prdata = 32'(st.ch[chi].count);
            dma_pkg::REG_PADDR: next_st.prdata = st.ch[chi].pbase;
            default:            next_st.prdata = st.ch[chi].mbase;
          endcase
        end
      end
    end

    // access phase write; clears here so engine sets below win
    if (wr) begin
      if (paddr == dma_pkg::OFS_CLEAR) begin
        for (int c = 0; c < dma_pkg::NCH; c++) begin
          // any-bit clears all three of the channel
          if (pwdata[4*c + dma_pkg::F_ANY] || pwdata[4*c + dma_pkg::F_DONE])
            next_st.ch[c].all_done_flag = 1'b0;                   // (R24)
          if (pwdata[4*c + dma_pkg::F_ANY] || pwdata[4*c + dma_pkg::F_HALF])
            next_st.ch[c].half_done_flag = 1'b0;                  // (R24)
          if (pwdata[4*c + dma_pkg::F_ANY] || pwdata[4*c + dma_pkg::F_FLT])
            next_st.ch[c].transfer_fault_flag = 1'b0;             // (R24)
        end
      end else if (paddr == dma_pkg::OFS_FORCE) begin
        for (int c = 0; c < dma_pkg::NCH; c++) begin
          // software trigger of each event
          if (pwdata[4*c + dma_pkg::F_DONE])
            next_st.ch[c].all_done_flag = 1'b1;                   // (R5)
          if (pwdata[4*c + dma_pkg::F_HALF])
            next_st.ch[c].half_done_flag = 1'b1;                  // (R5)
          if (pwdata[4*c + dma_pkg::F_FLT])
            next_st.ch[c].transfer_fault_flag = 1'b1;             // (R5)
        end
      end else if (paddr == dma_pkg::OFS_SELECT) begin
        for (int c = 0; c < dma_pkg::NCH; c++) begin
          next_st.ch[c].sel = pwdata[4*c +: 4];                   // (R8)
        end
      end else if (in_ch) begin
        unique case (rof)
          dma_pkg::REG_CFG: begin
            // enabling restarts both pointers from their bases
            if (pwdata[dma_pkg::B_ON] && !st.ch[chi].cfg[dma_pkg::B_ON]) begin
              next_st.ch[chi].pcur = st.ch[chi].pbase;
              next_st.ch[chi].mcur = st.ch[chi].mbase;
            end
            next_st.ch[chi].cfg = pwdata[dma_pkg::CFG_W-1:0];     // (R15)
          end
          dma_pkg::REG_COUNT: begin
            // ignored while the channel runs
            if (!st.ch[chi].cfg[dma_pkg::B_ON]) begin             // (R13)
              next_st.ch[chi].count  = pwdata[15:0];              // (R3)
              next_st.ch[chi].reload = pwdata[15:0];
            end
          end
          dma_pkg::REG_PADDR: begin
            if (!st.ch[chi].cfg[dma_pkg::B_ON]) begin
              next_st.ch[chi].pbase = pwdata;
              next_st.ch[chi].pcur  = pwdata;
            end
          end
          default: begin
            if (!st.ch[chi].cfg[dma_pkg::B_ON]) begin
              next_st.ch[chi].mbase = pwdata;
              next_st.ch[chi].mcur  = pwdata;
            end
          end
        endcase
      end
    end

    // source and destination of the served channel
    dir    = k.cfg[dma_pkg::B_DIR];                               // (R21)
    src_sz = dir ? k.cfg[dma_pkg::B_MSZ +: 2] : k.cfg[dma_pkg::B_PSZ +: 2];
    dst_sz = dir ? k.cfg[dma_pkg::B_PSZ +: 2] : k.cfg[dma_pkg::B_MSZ +: 2];

    // transfer engine: one item is a read then a write
    unique case (st.fsm)
      dma_pkg::ST_IDLE: begin
        if (grant_any) begin
          k = st.ch[grant_idx];
          dir = k.cfg[dma_pkg::B_DIR];
          next_st.cur       = grant_idx;
          next_st.bus.req   = 1'b1;
          next_st.bus.write = 1'b0;
          // memory side may read flash or sram
          next_st.bus.addr  = dir ? k.mcur : k.pcur;              // (R2) (R19)
          next_st.bus.size  = dir ? k.cfg[dma_pkg::B_MSZ +: 2]    // (R9) (R22)
                                  : k.cfg[dma_pkg::B_PSZ +: 2];
          next_st.fsm       = dma_pkg::ST_READ;
        end
      end
      dma_pkg::ST_READ: begin
        if (bus_ready) begin
          if (bus_err) begin
            // a failed access stops the channel
            next_st.bus.req = 1'b0;
            next_st.ch[st.cur].transfer_fault_flag = 1'b1;        // (R23)
            next_st.ch[st.cur].cfg[dma_pkg::B_ON]  = 1'b0;
            next_st.fsm = dma_pkg::ST_IDLE;
          end else begin
            // narrow read zero-extends; wide read keeps low part
            next_st.data      = bus_rdata & width_mask(src_sz);   // (R10)
            next_st.bus.wdata = bus_rdata & width_mask(src_sz);   // (R10)
            next_st.bus.write = 1'b1;
            next_st.bus.addr  = dir ? k.pcur : k.mcur;            // (R19)
            next_st.bus.size  = dst_sz;                           // (R9)
            next_st.fsm       = dma_pkg::ST_WRITE;
          end
        end
      end
      dma_pkg::ST_WRITE: begin
        if (bus_ready) begin
          next_st.bus.req = 1'b0;
          if (bus_err) begin
            next_st.ch[st.cur].transfer_fault_flag = 1'b1;        // (R23)
            next_st.ch[st.cur].cfg[dma_pkg::B_ON]  = 1'b0;
            next_st.fsm = dma_pkg::ST_IDLE;
          end else begin
            next_st.fsm = dma_pkg::ST_STEP;
          end
        end
      end
      dma_pkg::ST_STEP: begin
        k = next_st.ch[st.cur];
        k.count = k.count - 16'h0001;
        if (k.cfg[dma_pkg::B_PINC])                               // (R11)
          k.pcur = k.pcur + width_step(k.cfg[dma_pkg::B_PSZ +: 2]);  // (R12)
        if (k.cfg[dma_pkg::B_MINC])                               // (R11)
          k.mcur = k.mcur + width_step(k.cfg[dma_pkg::B_MSZ +: 2]);  // (R12)
        if (k.count == (k.reload >> 1))
          k.half_done_flag = 1'b1;                                // (R23)
        if (k.count == 16'h0000) begin
          k.all_done_flag = 1'b1;                                 // (R23)
          if (k.cfg[dma_pkg::B_CIRC]) begin                       // (R15)
            k.count = k.reload;                                   // (R14)
            k.pcur  = k.pbase;                                    // (R14)
            k.mcur  = k.mbase;                                    // (R14)
          end
        end
        next_st.ch[st.cur] = k;
        // acknowledge only a peripheral-paced item
        next_st.ack[st.cur] = !k.cfg[dma_pkg::B_M2M];             // (R4)
        next_st.fsm = dma_pkg::ST_HOLD;
      end
      default: begin
        // gap lets the acknowledged peripheral drop its request
        next_st.fsm = dma_pkg::ST_IDLE;                           // (R4)
      end
    endcase

    // each flag drives the channel irq through its enable
    for (int c = 0; c < dma_pkg::NCH; c++) begin
      next_st.irq[c] =
        (st.ch[c].all_done_flag && st.ch[c].cfg[dma_pkg::B_TCIE])
        || (st.ch[c].half_done_flag && st.ch[c].cfg[dma_pkg::B_HTIE])
        || (st.ch[c].transfer_fault_flag && st.ch[c].cfg[dma_pkg::B_TEIE]);  // (R5)
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from state
  assign prdata     = st.prdata;
  assign pready     = st.pready;
  assign pslverr    = st.pslverr;
  assign periph_ack = st.ack;
  assign mem_bus    = st.bus;
  assign irq        = st.irq;
endmodule
`default_nettype wire

// file: hdl/dma_pkg_arb.sv
// shared constants and carriers of the five-channel dma controller,
// and the sw_priority channel arbiter.
// assumes one clock domain; the arbiter is purely combinational.
`timescale 1ns/1ps
`default_nettype none

package dma_pkg;
  localparam int NCH = 5;                        // channel count
  localparam int NSRC = 16;                      // request lines per channel
  // register byte offsets
  localparam logic [7:0] OFS_STATUS    = 8'h00;  // event flags, read only
  localparam logic [7:0] OFS_CLEAR     = 8'h04;  // flag clear, write 1
  localparam logic [7:0] OFS_CH_BASE   = 8'h08;  // channel block start
  localparam logic [7:0] OFS_CH_STRIDE = 8'h14;  // channel block length
  localparam logic [7:0] OFS_CH_END    = 8'h6c;  // first byte past blocks
  localparam logic [7:0] OFS_SELECT    = 8'ha8;  // source select codes
  localparam logic [7:0] OFS_FORCE     = 8'hac;  // software flag trigger
  // offsets inside one channel block
  localparam logic [4:0] REG_CFG   = 5'h00;      // channel_config
  localparam logic [4:0] REG_COUNT = 5'h04;      // transfer_count
  localparam logic [4:0] REG_PADDR = 5'h08;      // periph_address
  localparam logic [4:0] REG_MADDR = 5'h0c;      // mem_address
  // channel_config fields
  localparam int CFG_W  = 15;
  localparam int B_ON   = 0;                     // channel_on
  localparam int B_TCIE = 1;                     // completion irq enable
  localparam int B_HTIE = 2;                     // half irq enable
  localparam int B_TEIE = 3;                     // fault irq enable
  localparam int B_DIR  = 4;                     // direction_sel
  localparam int B_CIRC = 5;                     // circular_en
  localparam int B_PINC = 6;                     // periph_addr_inc_en
  localparam int B_MINC = 7;                     // mem_addr_inc_en
  localparam int B_PSZ  = 8;                     // periph_width_sel, 2 bits
  localparam int B_MSZ  = 10;                    // mem_width_sel, 2 bits
  localparam int B_PRIO = 12;                    // sw_priority, 2 bits
  localparam int B_M2M  = 14;                    // mem_to_mem_en
  // flag layout per channel nibble of status and clear registers
  localparam int F_ANY  = 0;
  localparam int F_DONE = 1;
  localparam int F_HALF = 2;
  localparam int F_FLT  = 3;
  // width codes
  localparam logic [1:0] SZ_8  = 2'b00;
  localparam logic [1:0] SZ_16 = 2'b01;
  localparam logic [1:0] SZ_32 = 2'b10;
  localparam logic [15:0] CNT_RST = 16'h0000;    // count reset value

  typedef enum logic [2:0] {ST_IDLE, ST_READ, ST_WRITE, ST_STEP, ST_HOLD} dma_st_e;

  // one channel's programmed and running state
  typedef struct packed {
    logic [CFG_W-1:0] cfg;
    logic [15:0]      count;                     // remaining items
    logic [15:0]      reload;                    // programmed items
    logic [31:0]      pbase;
    logic [31:0]      mbase;
    logic [31:0]      pcur;
    logic [31:0]      mcur;
    logic [3:0]       sel;                       // source_select
    logic             half_done_flag;
    logic             all_done_flag;
    logic             transfer_fault_flag;
  } chan_s;

  // system bus request carrier
  typedef struct packed {
    logic        req;
    logic        write;
    logic [1:0]  size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } bus_req_s;
endpackage

// picks the highest sw_priority, lowest channel number on a tie
module dma_arbiter #(
  parameter int N  = 5,
  parameter int IW = 3
) (
  input  wire logic [N-1:0]   want,
  input  wire logic [2*N-1:0] prio,
  output logic                any,
  output logic [IW-1:0]       pick
);
  logic [1:0] best;                              // level of current pick

  // strict compare keeps the earlier, lower-numbered channel on ties
  always_comb begin
    best = 2'b00;
    any  = 1'b0;
    pick = '0;
    for (int i = 0; i < N; i++) begin
      if (want[i] && (!any || prio[2*i +: 2] > best)) begin  // (R16) (R18)
        any  = 1'b1;
        pick = IW'(i);
        best = prio[2*i +: 2];
      end
    end
  end
endmodule
`default_nettype wire
